// >>> src/pse_regs.svh
`ifndef PSE_REGS_SVH
`define PSE_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_MODE 8'h00
`define REG_STATUS 8'h04
`define REG_PORT 8'h08
`define REG_ACTH 8'h0c
`define REG_DISC 8'h10
`define REG_TIMES 8'h14
`define REG_IRQ_STAT 8'h18
`define REG_IRQ_MASK 8'h1c

// ----------------------------------------
// Fields and defaults
// ----------------------------------------
`define MODE_SOFT_RST_BIT 8
`define ADDR_UPPER 3'h2
`define ACTH_DEFAULT 3'h0
`define DISC_DEFAULT 8'h00
`define START_DEFAULT 8'h00
`define FAULT_DEFAULT 8'h00
`define IRQ_SHORT_RST_BIT 12

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 100
`define RST_MIN_US 300
`define RST_MIN_CYC ((`RST_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> src/pse_pkg.sv
package pse_pkg;

    // Encoding order matches the two-bit mode field
    typedef enum logic [1:0] {
        MODE_SHUTDOWN,
        MODE_MANUAL,
        MODE_SEMI,
        MODE_AUTO
    } port_mode_t;

endpackage : pse_pkg

// >>> src/pin_sync.sv
module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Pins in, synchronised out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_ff <= RST_VAL;
            q_ff <= RST_VAL;
        end else begin
            meta_ff <= d;
            q_ff <= meta_ff;
        end
    end

    assign q = q_ff;

endmodule : pin_sync

// >>> src/pse_port_control_pins.sv
`include "pse_regs.svh"

module pse_port_control_pins #(
    parameter int ADDR_W = 8,
    parameter logic [2:0] ACTH_DEF = `ACTH_DEFAULT,
    parameter logic [7:0] DISC_DEF = `DISC_DEFAULT,
    parameter logic [7:0] START_DEF = `START_DEFAULT,
    parameter logic [7:0] FAULT_DEF = `FAULT_DEFAULT
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Device pins
    input wire logic reset_pin_n,
    input wire logic [3:0] slave_id_inputs,
    input wire logic self_run_pin,
    input wire logic injector_pin,
    input wire logic [3:0] port_off_n,
    input wire logic ac_probe_sine_in,
    // Analog monitors
    input wire logic supply_ok,
    input wire logic overtemp,
    input wire logic [3:0] overcurrent,
    // Detection result, same clock
    input wire logic [3:0] det_valid,
    // Serial interface side
    output logic [6:0] bus_addr,
    output logic addr_ack_en,
    // Mode and programmed timing
    output logic midspan_mode,
    output logic [7:0] port_modes,
    output logic [2:0] ac_thresh_code,
    output logic [7:0] disconnect_wait_time,
    output logic [7:0] startup_time_code,
    output logic [7:0] fault_time_code,
    // Power stage and interrupt
    output logic [3:0] gate_on,
    output logic irq,
    output logic fault_alert_out,
    output logic fault_alert_oe_n
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic pin_n_s;
    logic [3:0] id_s;
    logic self_run_s;
    logic injector_s;
    logic [3:0] port_off_s;
    logic probe_ok_s;
    logic supply_s;
    logic overtemp_s;
    logic [3:0] oc_s;

    pin_sync #(
        .W(18),
        .RST_VAL(18'h00000)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d({reset_pin_n, slave_id_inputs, self_run_pin, injector_pin, port_off_n,
            ac_probe_sine_in, supply_ok, overtemp, overcurrent}),
        .q({pin_n_s, id_s, self_run_s, injector_s, port_off_s,
            probe_ok_s, supply_s, overtemp_s, oc_s})
    );

    // ----------------------------------------
    // Reset causes and pin latching
    // ----------------------------------------
    logic soft_rst_ff;
    logic hold_ff;
    logic pin_n_q_ff;
    logic [11:0] low_cnt_ff;
    logic [3:0] id_ff;
    logic self_run_ff;
    logic midspan_ff;
    logic ack_ff;

    wire hold_rst = !pin_n_s || !supply_s || overtemp_s || soft_rst_ff;
    wire rst_int = !aresetn || hold_rst;
    wire rel = hold_ff && !hold_rst;
    wire pin_rise = pin_n_s && !pin_n_q_ff;
    // Pulses shorter than the minimum still reset, but get flagged
    wire short_rst = pin_rise && (low_cnt_ff < 12'(`RST_MIN_CYC));
    wire [11:0] nxt_low_cnt = pin_n_s ? 12'h000 :
        (low_cnt_ff == 12'hfff) ? low_cnt_ff : low_cnt_ff + 12'h001;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_ff <= 1'b1;
            pin_n_q_ff <= 1'b1;
            low_cnt_ff <= 12'h000;
            ack_ff <= 1'b0;
        end else begin
            hold_ff <= hold_rst;
            pin_n_q_ff <= pin_n_s;
            low_cnt_ff <= nxt_low_cnt;
            ack_ff <= !hold_rst;
        end
    end

    // Pins read only at release; ignored while running
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            id_ff <= 4'hf;
            self_run_ff <= 1'b0;
            midspan_ff <= 1'b0;
        end else if (rel) begin
            id_ff <= id_s;
            self_run_ff <= self_run_s;
            midspan_ff <= injector_s;
        end
    end

    // ----------------------------------------
    // Bus decode helpers
    // ----------------------------------------
    function automatic logic reg_known(input logic [ADDR_W-1:0] a);
        logic [7:0] o;
        o = 8'(a);
        reg_known = (o == `REG_MODE) || (o == `REG_STATUS) || (o == `REG_PORT) ||
            (o == `REG_ACTH) || (o == `REG_DISC) || (o == `REG_TIMES) ||
            (o == `REG_IRQ_STAT) || (o == `REG_IRQ_MASK);
    endfunction : reg_known

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        merge = r;
    endfunction : merge

    // ----------------------------------------
    // AXI4-Lite write path
    // ----------------------------------------
    logic aw_have_ff;
    logic w_have_ff;
    logic [ADDR_W-1:0] aw_addr_ff;
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;

    assign s_axi_awready = !aw_have_ff && !bvalid_ff;
    assign s_axi_wready = !w_have_ff && !bvalid_ff;
    wire aw_hs = s_axi_awvalid && s_axi_awready;
    wire w_hs = s_axi_wvalid && s_axi_wready;
    wire wr_go = aw_have_ff && w_have_ff && !bvalid_ff;
    wire [7:0] wr_off = 8'(aw_addr_ff);
    wire wr_mode = wr_go && (wr_off == `REG_MODE);
    wire wr_port = wr_go && (wr_off == `REG_PORT);
    wire wr_acth = wr_go && (wr_off == `REG_ACTH);
    wire wr_disc = wr_go && (wr_off == `REG_DISC);
    wire wr_times = wr_go && (wr_off == `REG_TIMES);
    wire wr_istat = wr_go && (wr_off == `REG_IRQ_STAT);
    wire wr_imask = wr_go && (wr_off == `REG_IRQ_MASK);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            aw_addr_ff <= '0;
            w_data_ff <= 32'h00000000;
            w_strb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= 2'h0;
        end else begin
            if (aw_hs) begin
                aw_have_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end
            if (w_hs) begin
                w_have_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_ff <= 1'b0;
                w_have_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= reg_known(aw_addr_ff) ? 2'h0 : 2'h2;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    logic [7:0] mode_ff;
    logic [3:0] pwr_req_ff;
    logic [3:0] acd_en_ff;
    logic [2:0] acth_ff;
    logic [7:0] disc_ff;
    logic [7:0] start_ff;
    logic [7:0] fault_ff;
    logic [12:0] irq_stat_ff;
    logic [12:0] irq_mask_ff;
    logic [3:0] gate_ff;

    wire [31:0] wr_mode_v = merge({24'h000000, mode_ff}, w_data_ff, w_strb_ff);
    wire [31:0] wr_port_v = merge({24'h000000, acd_en_ff, pwr_req_ff}, w_data_ff, w_strb_ff);
    wire [31:0] wr_times_v = merge({16'h0000, fault_ff, start_ff}, w_data_ff, w_strb_ff);
    // Same start mode for every port
    // Live synced pin, since self_run_ff only takes its new value at this same edge
    wire [7:0] start_modes = self_run_s ? {4{pse_pkg::MODE_AUTO}}
                                         : {4{pse_pkg::MODE_SHUTDOWN}};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            soft_rst_ff <= 1'b0;
        end else begin
            soft_rst_ff <= wr_mode && w_strb_ff[1] && w_data_ff[`MODE_SOFT_RST_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (rst_int) begin
            mode_ff <= {4{pse_pkg::MODE_SHUTDOWN}};
            pwr_req_ff <= 4'h0;
            acd_en_ff <= 4'h0;
            acth_ff <= ACTH_DEF;
            disc_ff <= DISC_DEF;
            start_ff <= START_DEF;
            fault_ff <= FAULT_DEF;
            irq_mask_ff <= 13'h0000;
        end else begin
            if (rel) begin
                mode_ff <= start_modes;
            end else if (wr_mode) begin
                mode_ff <= wr_mode_v[7:0];
            end
            if (wr_port) begin
                pwr_req_ff <= wr_port_v[3:0];
                acd_en_ff <= wr_port_v[7:4];
            end
            if (wr_acth && w_strb_ff[0]) begin
                acth_ff <= w_data_ff[2:0];
            end
            if (wr_disc && w_strb_ff[0]) begin
                disc_ff <= w_data_ff[7:0];
            end
            if (wr_times) begin
                start_ff <= wr_times_v[7:0];
                fault_ff <= wr_times_v[15:8];
            end
            if (wr_imask) begin
                irq_mask_ff <= 13'(merge({19'h00000, irq_mask_ff}, w_data_ff, w_strb_ff));
            end
        end
    end

    // ----------------------------------------
    // Port power gating
    // ----------------------------------------
    logic [3:0] port_off_q_ff;
    logic [3:0] oc_q_ff;
    logic [3:0] allow;
    wire probe_fail = !probe_ok_s;

    for (genvar i = 0; i < 4; i++) begin : g_port
        wire pse_pkg::port_mode_t m = pse_pkg::port_mode_t'(mode_ff[2*i +: 2]);
        wire want = (m == pse_pkg::MODE_AUTO) ? det_valid[i]
                  : (m != pse_pkg::MODE_SHUTDOWN) && pwr_req_ff[i];
        assign allow[i] = want && port_off_s[i]
                       && !(acd_en_ff[i] && probe_fail)
                       && !irq_stat_ff[i];
    end

    always_ff @(posedge aclk) begin
        if (rst_int) begin
            gate_ff <= 4'h0;
            port_off_q_ff <= 4'hf;
            oc_q_ff <= 4'h0;
        end else begin
            gate_ff <= allow;
            port_off_q_ff <= port_off_s;
            oc_q_ff <= oc_s;
        end
    end

    // ----------------------------------------
    // Interrupt status, write one to clear
    // ----------------------------------------
    wire [3:0] ev_oc = oc_s & ~oc_q_ff;
    wire [3:0] ev_off = ~port_off_s & port_off_q_ff;
    wire [3:0] ev_probe = gate_ff & acd_en_ff & {4{probe_fail}};
    wire [12:0] ev_all = {short_rst, ev_probe, ev_off, ev_oc};
    wire [12:0] clr = wr_istat ? 13'(merge(32'h00000000, w_data_ff, w_strb_ff)) : 13'h0000;
    // Set wins so an event in the clearing cycle survives
    wire [12:0] nxt_irq_stat = (irq_stat_ff & ~clr) | ev_all;
    logic irq_ff;

    always_ff @(posedge aclk) begin
        if (rst_int) begin
            irq_stat_ff <= 13'h0000;
            irq_ff <= 1'b0;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            irq_ff <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    // ----------------------------------------
    // Register read path
    // ----------------------------------------
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;

    wire [7:0] rd_off = 8'(s_axi_araddr);
    wire [31:0] status_v = {18'h00000, probe_fail, gate_ff, self_run_ff, midspan_ff,
                            bus_addr};
    wire [31:0] rd_v =
        (rd_off == `REG_MODE) ? {24'h000000, mode_ff} :
        (rd_off == `REG_STATUS) ? status_v :
        (rd_off == `REG_PORT) ? {24'h000000, acd_en_ff, pwr_req_ff} :
        (rd_off == `REG_ACTH) ? {29'h00000000, acth_ff} :
        (rd_off == `REG_DISC) ? {24'h000000, disc_ff} :
        (rd_off == `REG_TIMES) ? {16'h0000, fault_ff, start_ff} :
        (rd_off == `REG_IRQ_STAT) ? {19'h00000, irq_stat_ff} :
        (rd_off == `REG_IRQ_MASK) ? {19'h00000, irq_mask_ff} : 32'h00000000;

    assign s_axi_arready = !rvalid_ff;
    wire ar_hs = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= 2'h0;
        end else if (ar_hs) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_v;
            rresp_ff <= reg_known(s_axi_araddr) ? 2'h0 : 2'h2;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign bus_addr = {`ADDR_UPPER, id_ff};
    assign addr_ack_en = ack_ff;
    assign midspan_mode = midspan_ff;
    assign port_modes = mode_ff;
    assign ac_thresh_code = acth_ff;
    assign disconnect_wait_time = disc_ff;
    assign startup_time_code = start_ff;
    assign fault_time_code = fault_ff;
    assign gate_on = gate_ff;
    assign irq = irq_ff;
    assign fault_alert_out = 1'b0;
    assign fault_alert_oe_n = !irq_ff;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_alert_pulls_low: assert property (
        (|(irq_stat_ff & irq_mask_ff)) && !hold_rst |=> !fault_alert_oe_n)
        else $error("alert not pulled low on pending fault");
    a_alert_releases: assert property (
        !(|(irq_stat_ff & irq_mask_ff)) |=> fault_alert_oe_n)
        else $error("alert held low with no pending fault");
    a_addr_latch: assert property (
        rel |=> bus_addr == {3'h2, $past(id_s)})
        else $error("bus address not latched from id pins");
    a_pins_frozen: assert property (
        !rel |=> $stable(midspan_ff) && $stable(self_run_ff) && $stable(id_ff))
        else $error("mode pins changed outside reset");
    a_start_auto: assert property (
        rel && self_run_s |=> port_modes == 8'hff)
        else $error("self-run high did not start auto");
    a_start_halt: assert property (
        rel && !self_run_s |=> port_modes == 8'h00)
        else $error("self-run low did not start shutdown");
    a_port_off: assert property (
        (port_off_s != 4'hf) |=> (gate_on & ~$past(port_off_s)) == 4'h0)
        else $error("port powered while its shutdown input low");
    a_probe_fail: assert property (
        probe_fail |=> (gate_on & $past(acd_en_ff)) == 4'h0)
        else $error("AC port powered with probe sine failed");
    a_no_ack: assert property (
        hold_rst |=> !addr_ack_en)
        else $error("address acknowledged during reset");
    a_reset_clear: assert property (
        hold_rst |=> gate_on == 4'h0 && irq_mask_ff == 13'h0000 && ac_thresh_code == ACTH_DEF)
        else $error("registers not at default in reset");
    a_mode_write: assert property (
        wr_mode && w_strb_ff[0] && !hold_rst && !rel |=> port_modes == $past(w_data_ff[7:0]))
        else $error("software mode write not applied");

    c_short_reset: cover property (short_rst);
    c_probe_shut: cover property ((|ev_probe) ##1 gate_on == 4'h0);
    c_auto_leave: cover property (rel && self_run_s ##[1:50] wr_mode);
    c_alert: cover property ($fell(fault_alert_oe_n));

endmodule : pse_port_control_pins

// >>> sim/host_axi_model.sv
module host_axi_model (
    // Clock
    input wire logic aclk,
    // Write channels
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    // Read channels
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    end

    // Software programs thresholds and times here
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic b_ok;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        b_ok = 1'b0;
        while (!b_ok) begin
            @(posedge aclk);
            // Released payload is scrambled, not left stale
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata <= ~d;
            end
            if (bready && bvalid) begin
                b_ok = 1'b1;
                r = bresp;
                bready <= 1'b0;
            end
        end
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic r_ok;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        r_ok = 1'b0;
        while (!r_ok) begin
            @(posedge aclk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr <= ~a;
            end
            if (rready && rvalid) begin
                r_ok = 1'b1;
                d = rdata;
                r = rresp;
                rready <= 1'b0;
            end
        end
    endtask : rd
endmodule : host_axi_model

// >>> sim/pse_port_control_pins_tb_top.sv
module pse_port_control_pins_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic aclk, aresetn, rst_pin_n, self_run, inj, probe, sup_ok;
    logic [3:0] id, off_n, gate_on;
    logic [7:0] awaddr, araddr, port_modes, disc_t, start_t, flt_t;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, ack_en, midspan, irq, al_out, al_oe_n;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic [6:0] bus_addr;
    logic [2:0] acth;
    logic ot;
    logic [3:0] det;
    int bad_count, n_tests;

    host_axi_model u_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));

    pse_port_control_pins u_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .reset_pin_n(rst_pin_n),
        .slave_id_inputs(id), .self_run_pin(self_run), .injector_pin(inj),
        .port_off_n(off_n), .ac_probe_sine_in(probe), .supply_ok(sup_ok),
        .overtemp(ot), .overcurrent(4'h0), .det_valid(det), .bus_addr(bus_addr),
        .addr_ack_en(ack_en), .midspan_mode(midspan), .port_modes(port_modes),
        .ac_thresh_code(acth), .disconnect_wait_time(disc_t),
        .startup_time_code(start_t), .fault_time_code(flt_t), .gate_on(gate_on),
        .irq(irq), .fault_alert_out(al_out), .fault_alert_oe_n(al_oe_n));

    // Open-drain alert line with board pull-up
    wire alert_line = al_oe_n ? 1'b1 : al_out;
    // Plain two-wire board: data out strapped to data
    wire serial_data_out_line = ack_en;
    wire serial_data_in_line = serial_data_out_line;

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc

    task automatic close_out();
        $display("Counts: %0d checks, %0d mismatches", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    // ----------------------------------------
    // Watchdog
    // ----------------------------------------
    initial begin
        cyc(12000);
        bad_count++;
        close_out();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        bad_count = 0;
        n_tests = 0;
        {aresetn, rst_pin_n, self_run, inj, probe, sup_ok} = 6'b011111;
        {ot, det} = 5'h00;
        id = 4'ha;
        off_n = 4'hf;
        cyc(8);
        aresetn <= 1'b1;
        cyc(10);
        chk(bus_addr, 7'h2a);
        chk(midspan, 1'b1);
        chk(port_modes, 8'hff);
        chk({ack_en, serial_data_in_line}, 2'b11);
        u_host.rd(8'h04, d, r);
        chk(d[8:0], 9'h1aa);
        {self_run, inj, id} <= 6'h05;
        cyc(6);
        chk({bus_addr, midspan, port_modes}, 16'h55ff);
        $display("Test latch done");

        u_host.rd(8'h14, d, r);
        chk({d, start_t, flt_t}, 48'h0);
        u_host.wr(8'h0c, 32'h7, r);
        chk(r, 2'h0);
        u_host.wr(8'h10, 32'ha5, r);
        u_host.wr(8'h14, 32'h3c5a, r);
        cyc(2);
        chk({acth, disc_t, start_t, flt_t}, 27'h7a55a3c);
        u_host.rd(8'h20, d, r);
        chk({r, d}, 34'h200000000);
        u_host.wr(8'h24, 32'h1, r);
        chk(r, 2'h2);
        $display("Test registers done");

        u_host.wr(8'h00, 32'h55, r);
        u_host.wr(8'h08, 32'h0f, r);
        u_host.wr(8'h1c, 32'hf0, r);
        cyc(4);
        chk({port_modes, gate_on}, 12'h55f);
        off_n <= 4'hb;
        cyc(5);
        chk({gate_on, irq, alert_line}, 6'h2e);
        off_n <= 4'hf;
        cyc(4);
        chk({irq, alert_line}, 2'b10);
        u_host.rd(8'h18, d, r);
        chk(d & 32'hf0, 32'h40);
        u_host.wr(8'h18, 32'h40, r);
        cyc(3);
        chk({irq, alert_line}, 2'b01);
        $display("Test shutdown and alert done");

        u_host.wr(8'h08, 32'hff, r);
        cyc(4);
        probe <= 1'b0;
        cyc(6);
        chk(gate_on, 4'h0);
        probe <= 1'b1;
        sup_ok <= 1'b0;
        id <= 4'h3;
        cyc(5);
        chk(ack_en, 1'b0);
        sup_ok <= 1'b1;
        cyc(8);
        chk({bus_addr, ack_en}, 8'h47);
        ot <= 1'b1;
        cyc(5);
        chk(ack_en, 1'b0);
        ot <= 1'b0;
        cyc(8);
        chk(ack_en, 1'b1);
        $display("Test probe and supply done");

        // Host holds the pin low; short pulse on purpose
        rst_pin_n <= 1'b0;
        cyc(20);
        chk(ack_en, 1'b0);
        rst_pin_n <= 1'b1;
        cyc(10);
        chk({bus_addr, midspan, port_modes}, 16'h4600);
        u_host.rd(8'h0c, d, r);
        chk(d, 32'h0);
        u_host.rd(8'h18, d, r);
        chk(d & 32'h10f0, 32'h1000);
        // Full 300 us hold at 100 ns a cycle leaves no short-pulse flag
        rst_pin_n <= 1'b0;
        cyc(3000);
        rst_pin_n <= 1'b1;
        cyc(10);
        u_host.rd(8'h18, d, r);
        chk(d & 32'h1000, 32'h0);
        $display("Test hardware reset done");

        self_run <= 1'b1;
        det <= 4'h5;
        cyc(4);
        u_host.wr(8'h00, 32'h100, r);
        cyc(4);
        chk({port_modes, gate_on}, 12'hff5);
        u_host.wr(8'h00, 32'h55, r);
        cyc(3);
        chk({port_modes, gate_on}, 12'h550);
        $display("Test soft reset and auto done");
        close_out();
    end
endmodule : pse_port_control_pins_tb_top
